// file: hw/line_image_formatter.sv
// image format stage: coding, binning, crop regions and test patterns
`timescale 1ns/1ps
// Functional notes
// - two codings: single colour lines, three planes
// - pixel size reads back as 8 bits
// - filter indicator: none or blue-green-red
// - single colour: select colour, switch it on/off
// - read-only buffer tag per colour line
// - sensor line length readable; region spans clamped to it, starts not checked
// - horizontal start always reads zero
// - output width is region sum over binning
// - height reads zero to three colour rows
// - along-line binning sums N adjacent pixels
// - across-row binning sums N rows
// - pattern off passes processed video
// - stepped grey rises every 512 pixels
// - horizontal, vertical and diagonal grey ramps
// - user gains applied to mid grey 128
// - patterns equal on all three channels
// - one to four regions; only inside pixels
// - region select steers start and span access
module line_image_formatter #(
	parameter int SENSOR_LEN = line_fmt_pkg::SENSOR_PIXELS
)(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [line_fmt_pkg::ADR_W-1:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatW,
	output logic [31:0] wbDatR,
	output logic wbAck,
	input wire logic inValid,
	input wire logic inLineStart,
	input wire logic [2:0][line_fmt_pkg::PIX_W-1:0] inPix,
	output logic outValid,
	output logic outLineStart,
	output logic [2:0][line_fmt_pkg::PIX_W-1:0] outPix,
	output logic [2:0] outPlaneOn
);
	import line_fmt_pkg::*;

	localparam int XW = $clog2(SENSOR_LEN);
	localparam int LW = XW + 1;
	localparam logic [LW-1:0] LINE_LEN = LW'(SENSOR_LEN);

	function automatic logic [BIN_W-1:0] clampBin(input logic [BIN_W-1:0] v);
		clampBin = (v == '0) ? BIN_ONE : ((v > BIN_MAX) ? BIN_MAX : v);
	endfunction : clampBin

	function automatic logic [PIX_W-1:0] sat8(input logic [SUM_W-1:0] v);
		sat8 = (v > SUM_W'(FULL_SCALE)) ? FULL_SCALE : v[PIX_W-1:0];
	endfunction : sat8

	// software settings
	coding_t coding_reg, coding_next;
	pattern_t pattern_reg, pattern_next;
	logic [BIN_W-1:0] hBin_reg, hBin_next, vBin_reg, vBin_next;
	logic [1:0] colourSel_reg, colourSel_next;
	logic [2:0] colourOn_reg, colourOn_next;
	logic [2:0] regionCount_reg, regionCount_next;
	logic [1:0] regionSel_reg, regionSel_next;
	logic [LW-1:0] regStart_reg [REGIONS];
	logic [LW-1:0] regStart_next [REGIONS];
	logic [LW-1:0] regSpan_reg [REGIONS];
	logic [LW-1:0] regSpan_next [REGIONS];
	logic [XW-1:0] gainAdr_reg, gainAdr_next;
	logic ack_reg, ack_next;
	logic [31:0] datR_reg, datR_next;

	// bus decode
	logic busReq, busWr, gainWr;
	logic [31:0] rdVal, wd;
	logic [LW+1:0] spanSum;
	logic [LW-1:0] outWidth;
	logic [1:0] height;

	assign busReq = wbCyc && wbStb && !ack_reg;
	// write lands on the edge where the master samples ack, as classic cycles expect
	assign busWr = wbCyc && wbStb && wbWe && ack_reg;
	assign gainWr = busWr && (wbAdr == ADR_GAIN_DATA);

	always_comb begin
		spanSum = '0;
		for (int i = 0; i < REGIONS; i++) begin
			if (3'(i) < regionCount_reg) begin
				spanSum = spanSum + (LW+2)'(regSpan_reg[i]);
			end
		end
		// divisor is one to four, so a small constant divide per case
		unique case (hBin_reg)
			3'h2: outWidth = LW'(spanSum / 2);
			3'h3: outWidth = LW'(spanSum / 3);
			3'h4: outWidth = LW'(spanSum / 4);
			default: outWidth = LW'(spanSum);
		endcase
		height = (coding_reg == COLOUR_THREE_PLANE_8BIT) ? 2'h3 :
			2'(colourOn_reg[0]) + 2'(colourOn_reg[1]) + 2'(colourOn_reg[2]);
	end

	always_comb begin
		unique case (wbAdr)
			ADR_FORMAT: rdVal = 32'({pattern_reg, 3'h0, coding_reg});
			ADR_BIN: rdVal = 32'({vBin_reg, 5'h0, hBin_reg});
			ADR_COLOUR_SEL: rdVal = 32'(colourSel_reg);
			ADR_COLOUR_ON: rdVal = 32'(colourOn_reg[colourSel_reg]);
			ADR_COLOUR_TAG: rdVal = 32'(colourSel_reg);
			ADR_SENSOR_LEN: rdVal = 32'(LINE_LEN);
			ADR_HSTART: rdVal = 32'h0000_0000;
			ADR_OUT_WIDTH: rdVal = 32'(outWidth);
			ADR_HEIGHT: rdVal = 32'(height);
			ADR_PIXEL_BITS: rdVal = 32'(BITS_PER_PIXEL);
			ADR_FILTER: rdVal = (coding_reg == COLOUR_THREE_PLANE_8BIT) ?
				32'(FILTER_BGR) : 32'(FILTER_NONE);
			ADR_REGION_COUNT: rdVal = 32'(regionCount_reg);
			ADR_REGION_SEL: rdVal = 32'(regionSel_reg);
			ADR_REGION_START: rdVal = 32'(regStart_reg[regionSel_reg]);
			ADR_REGION_SPAN: rdVal = 32'(regSpan_reg[regionSel_reg]);
			ADR_GAIN_ADDR: rdVal = 32'(gainAdr_reg);
			default: rdVal = 32'h0000_0000;
		endcase
		for (int b = 0; b < 4; b++) begin
			wd[8*b +: 8] = wbSel[b] ? wbDatW[8*b +: 8] : rdVal[8*b +: 8];
		end
	end

	always_comb begin
		coding_next = coding_reg;
		pattern_next = pattern_reg;
		hBin_next = hBin_reg;
		vBin_next = vBin_reg;
		colourSel_next = colourSel_reg;
		colourOn_next = colourOn_reg;
		regionCount_next = regionCount_reg;
		regionSel_next = regionSel_reg;
		regStart_next = regStart_reg;
		regSpan_next = regSpan_reg;
		gainAdr_next = gainAdr_reg;
		ack_next = busReq;
		datR_next = busReq ? rdVal : 32'h0000_0000;
		if (busWr) begin
			unique case (wbAdr)
				ADR_FORMAT: begin
					coding_next = coding_t'(wd[FMT_CODING_BIT]);
					pattern_next = pattern_t'(wd[FMT_PAT_LSB +: 3]);
				end
				ADR_BIN: begin
					hBin_next = clampBin(wd[BIN_H_LSB +: BIN_W]);
					vBin_next = clampBin(wd[BIN_V_LSB +: BIN_W]);
				end
				ADR_COLOUR_SEL: begin
					colourSel_next = (wd[1:0] > COLOUR_RED) ? COLOUR_RED : wd[1:0];
				end
				ADR_COLOUR_ON: colourOn_next[colourSel_reg] = wd[0];
				ADR_REGION_COUNT: begin
					regionCount_next = (wd[2:0] == '0) ? COUNT_ONE :
						((wd[2:0] > COUNT_MAX) ? COUNT_MAX : wd[2:0]);
				end
				ADR_REGION_SEL: regionSel_next = wd[1:0];
				ADR_REGION_START: begin
					// low bits dropped so a misaligned start snaps down
					regStart_next[regionSel_reg] =
						{wd[LW-1:ALIGN_BITS], {ALIGN_BITS{1'b0}}};
				end
				ADR_REGION_SPAN: begin
					regSpan_next[regionSel_reg] =
						(wd[LW-1:0] > LINE_LEN) ? LINE_LEN : wd[LW-1:0];
				end
				ADR_GAIN_ADDR: gainAdr_next = wd[XW-1:0];
				ADR_GAIN_DATA: gainAdr_next = gainAdr_reg + XW'(1);
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			coding_reg <= SINGLE_COLOUR_8BIT;
			pattern_reg <= PAT_OFF;
			hBin_reg <= BIN_ONE;
			vBin_reg <= BIN_ONE;
			colourSel_reg <= COLOUR_BLUE;
			colourOn_reg <= ALL_PLANES;
			regionCount_reg <= COUNT_ONE;
			regionSel_reg <= '0;
			for (int i = 0; i < REGIONS; i++) begin
				regStart_reg[i] <= '0;
				regSpan_reg[i] <= LINE_LEN;
			end
			gainAdr_reg <= '0;
			ack_reg <= 1'b0;
			datR_reg <= 32'h0000_0000;
		end else begin
			coding_reg <= coding_next;
			pattern_reg <= pattern_next;
			hBin_reg <= hBin_next;
			vBin_reg <= vBin_next;
			colourSel_reg <= colourSel_next;
			colourOn_reg <= colourOn_next;
			regionCount_reg <= regionCount_next;
			regionSel_reg <= regionSel_next;
			regStart_reg <= regStart_next;
			regSpan_reg <= regSpan_next;
			gainAdr_reg <= gainAdr_next;
			ack_reg <= ack_next;
			datR_reg <= datR_next;
		end
	end

	assign wbAck = ack_reg;
	assign wbDatR = datR_reg;

	// line-held copies of the settings and the video pipeline
	coding_t actCoding_reg, actCoding_next;
	pattern_t actPat_reg, actPat_next;
	logic [BIN_W-1:0] actH_reg, actH_next, actV_reg, actV_next;
	logic [2:0] actOn_reg, actOn_next, actCount_reg, actCount_next;
	logic [LW-1:0] actStart_reg [REGIONS];
	logic [LW-1:0] actStart_next [REGIONS];
	logic [LW-1:0] actEnd_reg [REGIONS];
	logic [LW-1:0] actEnd_next [REGIONS];
	logic [XW-1:0] xCnt_reg, xCnt_next, s1X_reg, s1X_next, curX;
	logic [7:0] row_reg, row_next;
	logic [BIN_W-1:0] vPhase_reg, vPhase_next, hCnt_reg, hCnt_next;
	logic s1Valid_reg, s1Valid_next, s2Valid_reg, s2Valid_next;
	logic [2:0][PIX_W-1:0] s1Pix_reg, s1Pix_next, src;
	logic [2:0][VSUM_W-1:0] s2Sum_reg, s2Sum_next, vSum, vRd;
	logic [2:0][SUM_W-1:0] hAcc_reg, hAcc_next;
	logic pend_reg, pend_next, oValid_reg, oValid_next, oStart_reg, oStart_next;
	logic [2:0][PIX_W-1:0] oPix_reg, oPix_next;
	logic [2:0] oOn_reg, oOn_next;
	logic [GAIN_W-1:0] gainRd;
	logic [GAIN_W+PIX_W-1:0] gained;
	logic [PIX_W-1:0] grey;
	logic lineGo, inRegion, vLast, hLast;

	assign lineGo = inValid && inLineStart;
	assign curX = inLineStart ? '0 : xCnt_reg;

	line_ram #(.WIDTH(GAIN_W), .DEPTH(SENSOR_LEN)) gainMem (
		.mclk(mclk),
		.wrEn(gainWr),
		.wrAdr(gainAdr_reg),
		.wrDat(wbDatW[GAIN_W-1:0]),
		.rdAdr(curX),
		.rdDat(gainRd)
	);

	line_ram #(.WIDTH(3 * VSUM_W), .DEPTH(SENSOR_LEN)) rowMem (
		.mclk(mclk),
		.wrEn(s1Valid_reg),
		.wrAdr(s1X_reg),
		.wrDat(vSum),
		.rdAdr(curX),
		.rdDat(vRd)
	);

	always_comb begin
		actCoding_next = actCoding_reg;
		actPat_next = actPat_reg;
		actH_next = actH_reg;
		actV_next = actV_reg;
		actOn_next = actOn_reg;
		actCount_next = actCount_reg;
		actStart_next = actStart_reg;
		actEnd_next = actEnd_reg;
		row_next = row_reg;
		vPhase_next = vPhase_reg;
		if (lineGo) begin
			// copies only move at a line start, so a line never mixes settings
			actCoding_next = coding_reg;
			actPat_next = pattern_reg;
			actH_next = hBin_reg;
			actV_next = vBin_reg;
			actOn_next = colourOn_reg;
			actCount_next = regionCount_reg;
			for (int i = 0; i < REGIONS; i++) begin
				actStart_next[i] = regStart_reg[i];
				actEnd_next[i] = regStart_reg[i] + regSpan_reg[i];
			end
			row_next = row_reg + 8'h01;
			// a changed factor restarts the row group
			vPhase_next = (vBin_reg != actV_reg || vPhase_reg + BIN_ONE >= vBin_reg) ?
				'0 : vPhase_reg + BIN_ONE;
		end
	end

	always_comb begin
		inRegion = 1'b0;
		// overlapping regions are sent once; software keeps starts ascending
		for (int i = 0; i < REGIONS; i++) begin
			if (3'(i) < actCount_next && LW'(curX) >= actStart_next[i] &&
				LW'(curX) < actEnd_next[i]) begin
				inRegion = 1'b1;
			end
		end
		xCnt_next = inValid ? curX + XW'(1) : xCnt_reg;
		s1Valid_next = inValid && inRegion;
		s1X_next = curX;
		s1Pix_next = inPix;
	end

	always_comb begin
		gained = MID_GREY * gainRd;
		unique case (actPat_reg)
			STEPPED_GREY_PER_BLOCK: grey = PIX_W'(s1X_reg >> BLOCK_SHIFT);
			ALONG_LINE_GREY_RAMP: grey = s1X_reg[PIX_W-1:0];
			ROW_TO_ROW_GREY_RAMP: grey = row_reg;
			DIAGONAL_GREY_RAMP: grey = s1X_reg[PIX_W-1:0] + row_reg;
			UPLOADED_GAIN_PATTERN: begin
				grey = (gained[GAIN_W+PIX_W-1:GAIN_FRAC] > (GAIN_W+PIX_W-GAIN_FRAC)'(FULL_SCALE)) ?
					FULL_SCALE : gained[GAIN_FRAC +: PIX_W];
			end
			default: grey = '0;
		endcase
		vLast = (vPhase_reg == actV_reg - BIN_ONE);
		for (int c = 0; c < 3; c++) begin
			// unknown pattern codes fall back to live video
			src[c] = (actPat_reg == PAT_OFF || actPat_reg > UPLOADED_GAIN_PATTERN) ?
				s1Pix_reg[c] : grey;
			vSum[c] = ((vPhase_reg == '0) ? '0 : vRd[c]) + VSUM_W'(src[c]);
		end
		s2Valid_next = s1Valid_reg && vLast;
		s2Sum_next = vSum;
	end

	always_comb begin
		hLast = (hCnt_reg == actH_reg - BIN_ONE);
		hAcc_next = hAcc_reg;
		hCnt_next = hCnt_reg;
		oValid_next = 1'b0;
		oStart_next = oStart_reg;
		oPix_next = oPix_reg;
		oOn_next = oOn_reg;
		pend_next = pend_reg;
		if (s2Valid_reg) begin
			for (int c = 0; c < 3; c++) begin
				hAcc_next[c] = hLast ? '0 : hAcc_reg[c] + SUM_W'(s2Sum_reg[c]);
				oPix_next[c] = hLast ? sat8(hAcc_reg[c] + SUM_W'(s2Sum_reg[c])) :
					oPix_reg[c];
			end
			hCnt_next = hLast ? '0 : hCnt_reg + BIN_ONE;
			oValid_next = hLast;
			oStart_next = hLast ? pend_reg : oStart_reg;
			pend_next = hLast ? 1'b0 : pend_reg;
			oOn_next = (actCoding_reg == COLOUR_THREE_PLANE_8BIT) ?
				ALL_PLANES : actOn_reg;
		end
		if (lineGo) begin
			// a partial group left at the line end is dropped
			hAcc_next = '0;
			hCnt_next = '0;
			pend_next = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			actCoding_reg <= SINGLE_COLOUR_8BIT;
			actPat_reg <= PAT_OFF;
			actH_reg <= BIN_ONE;
			actV_reg <= BIN_ONE;
			actOn_reg <= ALL_PLANES;
			actCount_reg <= COUNT_ONE;
			for (int i = 0; i < REGIONS; i++) begin
				actStart_reg[i] <= '0;
				actEnd_reg[i] <= '0;
			end
			row_reg <= '0;
			vPhase_reg <= '0;
			xCnt_reg <= '0;
			s1Valid_reg <= 1'b0;
			s1X_reg <= '0;
			s1Pix_reg <= '0;
			s2Valid_reg <= 1'b0;
			s2Sum_reg <= '0;
			hAcc_reg <= '0;
			hCnt_reg <= '0;
			pend_reg <= 1'b0;
			oValid_reg <= 1'b0;
			oStart_reg <= 1'b0;
			oPix_reg <= '0;
			oOn_reg <= '0;
		end else begin
			actCoding_reg <= actCoding_next;
			actPat_reg <= actPat_next;
			actH_reg <= actH_next;
			actV_reg <= actV_next;
			actOn_reg <= actOn_next;
			actCount_reg <= actCount_next;
			actStart_reg <= actStart_next;
			actEnd_reg <= actEnd_next;
			row_reg <= row_next;
			vPhase_reg <= vPhase_next;
			xCnt_reg <= xCnt_next;
			s1Valid_reg <= s1Valid_next;
			s1X_reg <= s1X_next;
			s1Pix_reg <= s1Pix_next;
			s2Valid_reg <= s2Valid_next;
			s2Sum_reg <= s2Sum_next;
			hAcc_reg <= hAcc_next;
			hCnt_reg <= hCnt_next;
			pend_reg <= pend_next;
			oValid_reg <= oValid_next;
			oStart_reg <= oStart_next;
			oPix_reg <= oPix_next;
			oOn_reg <= oOn_next;
		end
	end

	assign outValid = oValid_reg;
	assign outLineStart = oStart_reg;
	assign outPix = oPix_reg;
	assign outPlaneOn = oOn_reg;

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence readOf(logic [ADR_W-1:0] a);
		wbCyc && wbStb && !wbWe && !wbAck && wbAdr == a;
	endsequence

	a_pixel_bits_read: assert property (
		readOf(ADR_PIXEL_BITS) |=> wbAck && wbDatR == 32'(BITS_PER_PIXEL))
		else $error("pixel size not 8");
	a_filter_matches: assert property (
		readOf(ADR_FILTER) |=> wbDatR == ((coding_reg == COLOUR_THREE_PLANE_8BIT) ?
			32'(FILTER_BGR) : 32'(FILTER_NONE)))
		else $error("filter indicator wrong");
	a_hstart_zero: assert property (
		readOf(ADR_HSTART) |=> wbDatR == 32'h0000_0000)
		else $error("horizontal start not zero");
	a_planar_all_planes: assert property (
		outValid && $past(actCoding_reg) == COLOUR_THREE_PLANE_8BIT |-> outPlaneOn == ALL_PLANES)
		else $error("plane mask in colour coding");
	a_start_aligned: assert property (
		regStart_reg[regionSel_reg][ALIGN_BITS-1:0] == '0)
		else $error("region start misaligned");
	a_count_range: assert property (
		regionCount_reg >= COUNT_ONE && regionCount_reg <= COUNT_MAX)
		else $error("region count out of range");
	a_hcount_bound: assert property (
		hCnt_reg < actH_reg)
		else $error("binning counter past factor");
	a_settings_held: assert property (
		!lineGo |=> $stable(actCoding_reg) && $stable(actPat_reg) && $stable(actH_reg))
		else $error("settings moved inside a line");
	a_height_range: assert property (
		coding_reg == COLOUR_THREE_PLANE_8BIT |-> height == 2'h3)
		else $error("height wrong in colour coding");
endmodule : line_image_formatter

// file: hw/line_fmt_pkg.sv
// constants, register map and types of the line image formatter
package line_fmt_pkg;
	localparam int SENSOR_PIXELS = 16384;
	localparam int REGIONS = 4;
	localparam int MAX_BIN = 4;
	localparam int PIX_W = 8;
	localparam int VSUM_W = 10;
	localparam int SUM_W = 12;
	localparam int GAIN_W = 16;
	localparam int GAIN_FRAC = 12;
	localparam int ADR_W = 8;
	localparam int ALIGN_BITS = 5;
	localparam int BLOCK_SHIFT = 9;
	localparam int FMT_CODING_BIT = 0;
	localparam int FMT_PAT_LSB = 4;
	localparam int BIN_H_LSB = 0;
	localparam int BIN_V_LSB = 8;
	localparam int BIN_W = 3;

	localparam logic [ADR_W-1:0] ADR_FORMAT = 8'h00;
	localparam logic [ADR_W-1:0] ADR_BIN = 8'h04;
	localparam logic [ADR_W-1:0] ADR_COLOUR_SEL = 8'h08;
	localparam logic [ADR_W-1:0] ADR_COLOUR_ON = 8'h0C;
	localparam logic [ADR_W-1:0] ADR_COLOUR_TAG = 8'h10;
	localparam logic [ADR_W-1:0] ADR_SENSOR_LEN = 8'h14;
	localparam logic [ADR_W-1:0] ADR_HSTART = 8'h18;
	localparam logic [ADR_W-1:0] ADR_OUT_WIDTH = 8'h1C;
	localparam logic [ADR_W-1:0] ADR_HEIGHT = 8'h20;
	localparam logic [ADR_W-1:0] ADR_PIXEL_BITS = 8'h24;
	localparam logic [ADR_W-1:0] ADR_FILTER = 8'h28;
	localparam logic [ADR_W-1:0] ADR_REGION_COUNT = 8'h2C;
	localparam logic [ADR_W-1:0] ADR_REGION_SEL = 8'h30;
	localparam logic [ADR_W-1:0] ADR_REGION_START = 8'h34;
	localparam logic [ADR_W-1:0] ADR_REGION_SPAN = 8'h38;
	localparam logic [ADR_W-1:0] ADR_GAIN_ADDR = 8'h3C;
	localparam logic [ADR_W-1:0] ADR_GAIN_DATA = 8'h40;

	localparam logic [7:0] BITS_PER_PIXEL = 8'h08;
	localparam logic [7:0] FILTER_NONE = 8'h00;
	localparam logic [7:0] FILTER_BGR = 8'h01;
	localparam logic [7:0] MID_GREY = 8'h80;
	localparam logic [7:0] FULL_SCALE = 8'hFF;
	localparam logic [BIN_W-1:0] BIN_ONE = 3'h1;
	localparam logic [BIN_W-1:0] BIN_MAX = 3'h4;
	localparam logic [2:0] COUNT_ONE = 3'h1;
	localparam logic [2:0] COUNT_MAX = 3'h4;
	localparam logic [2:0] ALL_PLANES = 3'h7;
	localparam logic [1:0] COLOUR_BLUE = 2'h0;
	localparam logic [1:0] COLOUR_RED = 2'h2;

	typedef enum logic [0:0] {
		SINGLE_COLOUR_8BIT = 1'b0,
		COLOUR_THREE_PLANE_8BIT = 1'b1
	} coding_t;

	typedef enum logic [2:0] {
		PAT_OFF = 3'b000,
		STEPPED_GREY_PER_BLOCK = 3'b001,
		ALONG_LINE_GREY_RAMP = 3'b010,
		ROW_TO_ROW_GREY_RAMP = 3'b011,
		DIAGONAL_GREY_RAMP = 3'b100,
		UPLOADED_GAIN_PATTERN = 3'b101
	} pattern_t;
endpackage : line_fmt_pkg

// file: hw/line_ram.sv
// simple dual-port memory with registered read data
`timescale 1ns/1ps
module line_ram #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16384
)(
	input wire logic mclk,
	input wire logic wrEn,
	input wire logic [$clog2(DEPTH)-1:0] wrAdr,
	input wire logic [WIDTH-1:0] wrDat,
	input wire logic [$clog2(DEPTH)-1:0] rdAdr,
	output logic [WIDTH-1:0] rdDat
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rd_reg;

	// no reset: contents are undefined until written
	always_ff @(posedge mclk) begin
		if (wrEn) begin
			mem[wrAdr] <= wrDat;
		end
		rd_reg <= mem[rdAdr];
	end

	assign rdDat = rd_reg;
endmodule : line_ram

// file: verif/grabber_model.sv
// frame grabber model: collects every pixel that arrives on the video link
`timescale 1ns/1ps
module grabber_model (
	input wire logic mclk,
	input wire logic outValid,
	input wire logic outLineStart,
	input wire logic [2:0][7:0] outPix
);
	// each entry is line start flag over red, green, blue
	logic [24:0] pixQ[$];

	// no back-pressure exists on the link, so every pulse must be taken at once
	always @(posedge mclk) begin
		if (outValid === 1'b1) begin
			pixQ.push_back({outLineStart, outPix});
		end
	end
endmodule : grabber_model

// file: verif/line_image_formatter_test.sv
// self-checking bench of the line image formatter
`timescale 1ns/1ps
module line_image_formatter_test;
	import line_fmt_pkg::*;
	localparam int LEN = 1024;
	logic mclk, reset_n, wbCyc, wbStb, wbWe, wbAck, inValid, inLineStart;
	logic outValid, outLineStart;
	logic [ADR_W-1:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDatW, wbDatR, rd;
	logic [2:0][7:0] inPix, outPix;
	logic [2:0] outPlaneOn;
	int bad_count = 0;
	int tests_run = 0;

	line_image_formatter #(.SENSOR_LEN(LEN)) dut (.mclk, .reset_n, .wbCyc, .wbStb, .wbWe,
		.wbAdr, .wbSel, .wbDatW, .wbDatR, .wbAck, .inValid, .inLineStart, .inPix,
		.outValid, .outLineStart, .outPix, .outPlaneOn);
	grabber_model grab (.mclk, .outValid, .outLineStart, .outPix);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// classic cycle; the wait is bounded so a silent slave cannot hang the run
	task automatic wb(input logic we, input logic [ADR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDatW <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		if (n >= 20) check(32'h0, 32'h1);
		rd = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask : wb

	task automatic rdchk(input logic [ADR_W-1:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rdchk

	// blue x+base, green one more, red two more; idle tail covers the latency
	task automatic send_line(input int n, input int base, input bit clr);
		if (clr) grab.pixQ.delete();
		for (int x = 0; x < n; x++) begin
			@(posedge mclk);
			inValid <= 1'b1;
			inLineStart <= (x == 0);
			inPix <= {8'(x + base + 2), 8'(x + base + 1), 8'(x + base)};
		end
		@(posedge mclk);
		inValid <= 1'b0;
		inLineStart <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask : send_line

	function automatic logic [24:0] q(input int i);
		return (i < grab.pixQ.size()) ? grab.pixQ[i] : 25'h1FFFFFF;
	endfunction : q

	function automatic logic [24:0] ev(input int x, input bit s);
		return {s, 8'(x + 2), 8'(x + 1), 8'(x)};
	endfunction : ev

	task automatic t_regs();
		rdchk(ADR_PIXEL_BITS, 32'h8);
		rdchk(ADR_FILTER, 32'h0);
		rdchk(ADR_HSTART, 32'h0);
		rdchk(ADR_SENSOR_LEN, 32'(LEN));
		rdchk(ADR_OUT_WIDTH, 32'(LEN));
		rdchk(ADR_HEIGHT, 32'h3);
		rdchk(8'hFC, 32'h0);
		wb(1'b1, ADR_PIXEL_BITS, 32'h10);
		rdchk(ADR_PIXEL_BITS, 32'h8);
		wb(1'b1, ADR_FORMAT, 32'h1);
		rdchk(ADR_FILTER, 32'h1);
		rdchk(ADR_HEIGHT, 32'h3);
		$display("test regs done");
	endtask : t_regs

	task automatic t_pass();
		send_line(4, 16, 1'b1);
		check(grab.pixQ.size(), 32'h4);
		for (int i = 0; i < 4; i++) check(q(i), ev(16 + i, i == 0));
		check(outPlaneOn, 32'h7);
		$display("test pass done");
	endtask : t_pass

	task automatic t_bin();
		wb(1'b1, ADR_BIN, 32'h102);
		rdchk(ADR_OUT_WIDTH, 32'(LEN / 2));
		send_line(5, 0, 1'b1);
		check(grab.pixQ.size(), 32'h2);
		check(q(0), {1'b1, 8'h05, 8'h03, 8'h01});
		check(q(1), {1'b0, 8'h09, 8'h07, 8'h05});
		wb(1'b1, ADR_BIN, 32'h201);
		send_line(2, 16, 1'b1);
		send_line(2, 16, 1'b0);
		check(grab.pixQ.size(), 32'h2);
		check(q(0), {1'b1, 8'h24, 8'h22, 8'h20});
		wb(1'b1, ADR_BIN, 32'h101);
		$display("test bin done");
	endtask : t_bin

	task automatic t_regions();
		wb(1'b1, ADR_REGION_COUNT, 32'h2);
		wb(1'b1, ADR_REGION_SEL, 32'h0);
		wb(1'b1, ADR_REGION_SPAN, 32'h60);
		wb(1'b1, ADR_REGION_SEL, 32'h1);
		wb(1'b1, ADR_REGION_START, 32'h81);
		wb(1'b1, ADR_REGION_SPAN, 32'h60);
		rdchk(ADR_REGION_START, 32'h80);
		wb(1'b1, ADR_REGION_SEL, 32'h0);
		rdchk(ADR_REGION_START, 32'h0);
		rdchk(ADR_OUT_WIDTH, 32'hC0);
		send_line(256, 0, 1'b1);
		check(grab.pixQ.size(), 32'hC0);
		check(q(0), ev(0, 1));
		check(q(95), ev(95, 0));
		check(q(96), ev(128, 0));
		check(q(191), ev(223, 0));
		wb(1'b1, ADR_REGION_COUNT, 32'h1);
		wb(1'b1, ADR_REGION_SPAN, 32'(LEN));
		$display("test regions done");
	endtask : t_regions

	// ramps are judged against their own first pixel where the row count is free
	task automatic t_patterns();
		logic [24:0] first, cur, prev;
		wb(1'b1, ADR_FORMAT, 32'h21);
		send_line(4, 80, 1'b1);
		for (int i = 0; i < 4; i++) check(q(i), {i == 0, {3{8'(i)}}});
		wb(1'b1, ADR_FORMAT, 32'h31);
		send_line(2, 80, 1'b1);
		send_line(2, 80, 1'b0);
		first = q(0);
		check(q(1), {1'b0, {3{first[7:0]}}});
		check(q(2), {1'b1, {3{8'(first[7:0] + 8'h01)}}});
		wb(1'b1, ADR_FORMAT, 32'h41);
		send_line(4, 80, 1'b1);
		first = q(0);
		for (int i = 1; i < 4; i++) check(q(i), {1'b0, {3{8'(first[7:0] + 8'(i))}}});
		wb(1'b1, ADR_FORMAT, 32'h11);
		send_line(600, 0, 1'b1);
		first = q(0);
		prev = q(511);
		cur = q(512);
		check(prev, {1'b0, {3{first[7:0]}}});
		check(cur[7:0] > prev[7:0], 32'h1);
		check(q(599), cur);
		$display("test patterns done");
	endtask : t_patterns

	task automatic t_user();
		wb(1'b1, ADR_GAIN_ADDR, 32'h0);
		wb(1'b1, ADR_GAIN_DATA, 32'h1000);
		wb(1'b1, ADR_GAIN_DATA, 32'h2000);
		wb(1'b1, ADR_GAIN_DATA, 32'h0800);
		wb(1'b1, ADR_GAIN_DATA, 32'h1000);
		wb(1'b1, ADR_FORMAT, 32'h51);
		send_line(4, 0, 1'b1);
		check(q(0), {1'b1, 24'h808080});
		check(q(1), {1'b0, 24'hFFFFFF});
		check(q(2), {1'b0, 24'h404040});
		check(q(3), {1'b0, 24'h808080});
		$display("test user done");
	endtask : t_user

	task automatic t_mono();
		wb(1'b1, ADR_FORMAT, 32'h0);
		wb(1'b1, ADR_COLOUR_SEL, 32'h1);
		wb(1'b1, ADR_COLOUR_ON, 32'h0);
		rdchk(ADR_COLOUR_TAG, 32'h1);
		rdchk(ADR_HEIGHT, 32'h2);
		send_line(2, 0, 1'b1);
		check(outPlaneOn, 32'h5);
		check(q(0), ev(0, 1));
		wb(1'b1, ADR_FORMAT, 32'h1);
		rdchk(ADR_HEIGHT, 32'h3);
		send_line(2, 0, 1'b1);
		check(outPlaneOn, 32'h7);
		$display("test mono done");
	endtask : t_mono

	// whole run is about 1100 cycles; the limit leaves ample margin
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		end_of_test();
	end

	initial begin
		reset_n = 1'b0;
		{wbCyc, wbStb, wbWe, inValid, inLineStart} = 5'h00;
		wbAdr = 8'h00;
		wbSel = 4'hF;
		wbDatW = 32'h0;
		inPix = 24'h000000;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		t_regs();
		t_pass();
		t_bin();
		t_regions();
		t_patterns();
		t_user();
		t_mono();
		end_of_test();
	end
endmodule : line_image_formatter_test
